// ==== logic/rcv_consts.svh ====
`ifndef RCV_CONSTS_SVH
`define RCV_CONSTS_SVH

// register offsets on the local port
`define RCV_OFS_CAUSE      3'h0
`define RCV_OFS_VMON       3'h1
`define RCV_OFS_TEMP       3'h2
`define RCV_OFS_CORE       3'h3
`define RCV_OFS_IRQ_STAT   3'h4
`define RCV_OFS_IRQ_MASK   3'h5
`define RCV_OFS_LIVE       3'h6

// reset cause flag positions
`define RCV_BIT_PON        0
`define RCV_BIT_PIN        1
`define RCV_BIT_BROWN      2
`define RCV_BIT_WDOG       3
`define RCV_BIT_TEMP       5
`define RCV_CAUSE_USED     8'h2F

// control bit positions
`define RCV_BIT_BO_EN      0
`define RCV_BIT_BO_LVL     1
`define RCV_BIT_TSD_EN     0
`define RCV_BIT_VSEL       1

// event bits in the interrupt status register
`define RCV_EV_PIN         0
`define RCV_EV_BROWN       1
`define RCV_EV_WDOG        2
`define RCV_EV_TEMP        3
`define RCV_EV_W           4

// reset values
`define RCV_CAUSE_RST      8'h01
`define RCV_CTRL_RST       8'h00

// vector map
`define RCV_ADDR_W         12
`define RCV_NUM_VEC        26
`define RCV_RESET_ADDR     12'h000
`define RCV_VEC_FIRST      12'h001
`define RCV_BOOT_ADDR      12'hC00

// timing
`define RCV_CLK_NS         10
`define RCV_T_BOD_NS       2000
`define RCV_T_PIN_NS       2000
`define RCV_TOUT_CYC       64

`endif

// ==== logic/rcv_pkg.sv ====
`include "rcv_consts.svh"

package rcv_pkg;

  // reset sequencer phases
  typedef enum logic [1:0] {
    RCV_ST_HOLD  = 2'b00,
    RCV_ST_DELAY = 2'b01,
    RCV_ST_RUN   = 2'b10
  } rcv_state_type;

  // vector handed to the core
  typedef struct packed {
    logic                   valid;
    logic [`RCV_ADDR_W-1:0] addr;
  } rcv_vector_type;

  // local register port request
  typedef struct packed {
    logic       we;
    logic       re;
    logic [2:0] addr;
    logic [7:0] wdata;
  } rcv_req_type;

endpackage

// ==== logic/rcv_pulse_filter.sv ====
`timescale 1ns/1ps
`default_nettype none

// qualifies a level: high out only after it stays high longer than CNT cycles
module rcv_pulse_filter
  import rcv_pkg::*;
#(
  parameter int CNT = 200
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic level_in,
  output var  logic level_ok
);

  localparam int W = $clog2(CNT + 2);

  logic [W-1:0] cnt_reg;

  // saturating run-length counter, restarts on any drop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= '0;
    else if (!level_in)
      cnt_reg <= '0;
    else if (cnt_reg <= W'(CNT))
      cnt_reg <= cnt_reg + W'(1);
  end

  // strictly longer than CNT cycles
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      level_ok <= 1'b0;
    else
      level_ok <= level_in && (cnt_reg >= W'(CNT));
  end

endmodule

`default_nettype wire

// ==== logic/rcv_reset_vector.sv ====
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "rcv_consts.svh"

// How it works
// RQ1: level select bit picks 1.8V or 2.0V
// RQ2: brown-out resets at once, releases after delay
// RQ3: only drops longer than 2us count
// RQ4: watchdog pulse one cycle, delay from its fall
// RQ5: overtemp resets, disables all but sensor
// RQ6: unused cause bits read zero
// RQ7: overtemp flag set when enabled, zero-write clears
// RQ8: watchdog flag set when enabled, zero-write clears
// RQ9: brown-out flag set when enabled, zero-write clears
// RQ10: pin reset flag, zero-write clears
// RQ11: power-on flag cleared only by software
// RQ12: software reads then clears flags early
// RQ13: all resets share one reset vector
// RQ14: 26 vectors at 0x001 to 0x01A
// RQ15: select bit adds boot start to vectors
// RQ16: programmed fuse starts at boot address
// RQ17: fuse and select decode vector placement
// RQ18: lowest pending vector number served first
module rcv_reset_vector
  import rcv_pkg::*;
#(
  parameter int                   TOUT_CYC  = `RCV_TOUT_CYC,
  parameter int                   NUM_VEC   = `RCV_NUM_VEC,
  parameter logic [`RCV_ADDR_W-1:0] BOOT_ADDR = `RCV_BOOT_ADDR
)
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  // local register port
  input  wire logic [2:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_we,
  input  wire logic                reg_re,
  output var  logic [7:0]          reg_rdata,
  // analog and pin side, asynchronous
  input  wire logic                supply_low,
  input  wire logic                reset_pin_n,
  input  wire logic                overtemp,
  input  wire logic                boot_reset_fuse,
  // watchdog side, same clock
  input  wire logic                watchdog_enable,
  input  wire logic                watchdog_timeout,
  // interrupt requests from peripherals, same clock
  input  wire logic [NUM_VEC-1:0]  irq_req,
  // outputs
  output var  logic                brownout_level_select,
  output var  logic                brownout_enable,
  output var  logic                core_reset,
  output var  logic                watchdog_reset_pulse,
  output var  logic                shutdown_active,
  output var  logic [`RCV_ADDR_W-1:0] reset_addr,
  output var  rcv_vector_type      irq_vector,
  output logic                     irq
);

  localparam int T_BOD_CYC = (`RCV_T_BOD_NS + `RCV_CLK_NS - 1) / `RCV_CLK_NS;
  localparam int T_PIN_CYC = (`RCV_T_PIN_NS + `RCV_CLK_NS - 1) / `RCV_CLK_NS;
  localparam int TW        = $clog2(TOUT_CYC + 1);
  localparam int VW        = $clog2(NUM_VEC);

  rcv_req_type     req;
  rcv_state_type   state_reg;
  rcv_state_type   state_next;
  logic [TW-1:0]   tout_reg;
  logic [3:0]      sync1_reg;
  logic [3:0]      sync2_reg;
  logic            bo_seen;
  logic            pin_seen;
  logic            temp_hit;
  logic            temp_hit_d_reg;
  logic            src_active;
  logic [7:0]      cause_reg;
  logic [7:0]      vmon_reg;
  logic [7:0]      temp_reg;
  logic [7:0]      core_reg;
  logic [`RCV_EV_W-1:0] irq_stat_reg;
  logic [`RCV_EV_W-1:0] irq_mask_reg;
  logic [`RCV_EV_W-1:0] ev;
  logic            fuse_reg;
  logic            ev_pin;
  logic            ev_brown;
  logic            ev_wdog;
  logic            ev_temp;
  logic            pin_seen_d_reg;
  logic            bo_seen_d_reg;
  logic            pick_valid;
  logic [VW-1:0]   pick_idx;
  logic [`RCV_ADDR_W-1:0] vec_base;

  assign req.we    = reg_we;
  assign req.re    = reg_re;
  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;

  // two-flop synchronisers; reset to idle levels (pin high, fuse unprogrammed) so no false edge follows reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg <= 4'hA;
      sync2_reg <= 4'hA;
    end
    else
    begin
      sync1_reg <= {boot_reset_fuse, overtemp, reset_pin_n, supply_low};
      sync2_reg <= sync1_reg;
    end
  end

  // fuse is sampled continuously after release; it is static in use
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      fuse_reg <= 1'b1;
    else
      fuse_reg <= sync2_reg[3];
  end

  // brown-out glitch filter, short dips are ignored
  rcv_pulse_filter #(
    .CNT      (T_BOD_CYC)
  ) u_bo_filter (
    .clk      (clk),
    .arst_n   (arst_n),
    .level_in (sync2_reg[0] & vmon_reg[`RCV_BIT_BO_EN]),
    .level_ok (bo_seen)
  ); // RQ3

  // reset pin needs the same minimum low time
  rcv_pulse_filter #(
    .CNT      (T_PIN_CYC)
  ) u_pin_filter (
    .clk      (clk),
    .arst_n   (arst_n),
    .level_in (~sync2_reg[1]),
    .level_ok (pin_seen)
  );

  // threshold choice goes straight to the comparator
  assign brownout_level_select = vmon_reg[`RCV_BIT_BO_LVL]; // RQ1
  assign brownout_enable       = vmon_reg[`RCV_BIT_BO_EN];

  // overtemp only acts while shutdown is enabled
  assign temp_hit = sync2_reg[2] & temp_reg[`RCV_BIT_TSD_EN];

  // watchdog reset pulse, exactly one cycle per time-out
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      watchdog_reset_pulse <= 1'b0;
    else
      watchdog_reset_pulse <= watchdog_timeout & watchdog_enable & ~watchdog_reset_pulse; // RQ4
  end

  // any source holds the core; the watchdog pulse only for its one cycle
  assign src_active = bo_seen | pin_seen | temp_hit | watchdog_reset_pulse; // RQ2 RQ13

  // sequencer: hold while a source is live, then run the delay counter
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RCV_ST_HOLD:
        if (!src_active)
          state_next = RCV_ST_DELAY; // RQ4
      RCV_ST_DELAY:
        if (src_active)
          state_next = RCV_ST_HOLD;
        else if (tout_reg == TW'(TOUT_CYC - 1))
          state_next = RCV_ST_RUN; // RQ2
      RCV_ST_RUN:
        if (src_active)
          state_next = RCV_ST_HOLD; // RQ2
      default:
        state_next = RCV_ST_HOLD;
    endcase
  end

  // power-on release enters the delay directly
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= RCV_ST_DELAY;
    else
      state_reg <= state_next;
  end

  // time-out counter, cleared whenever the delay is restarted
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tout_reg <= '0;
    else if (state_reg != RCV_ST_DELAY || src_active)
      tout_reg <= '0;
    else
      tout_reg <= tout_reg + TW'(1);
  end

  // reset goes up in the cycle a source is seen, no waiting on the delay
  always_comb
  begin
    core_reset = (state_reg != RCV_ST_RUN) | src_active; // RQ2
  end

  // shutdown kills ports and timers; the sensor path stays live
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      shutdown_active <= 1'b0;
    else
      shutdown_active <= temp_hit; // RQ5
  end

  // edge detect of qualified sources so each reset is one event
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      temp_hit_d_reg <= 1'b0;
      pin_seen_d_reg <= 1'b0;
      bo_seen_d_reg  <= 1'b0;
    end
    else
    begin
      temp_hit_d_reg <= temp_hit;
      pin_seen_d_reg <= pin_seen;
      bo_seen_d_reg  <= bo_seen;
    end
  end

  assign ev_temp  = temp_hit & ~temp_hit_d_reg;
  assign ev_pin   = pin_seen & ~pin_seen_d_reg;
  assign ev_brown = bo_seen & ~bo_seen_d_reg;
  assign ev_wdog  = watchdog_reset_pulse;

  // cause flags: hardware set beats a same-cycle software clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cause_reg <= `RCV_CAUSE_RST; // RQ11
    else
    begin
      if (req.we && req.addr == `RCV_OFS_CAUSE)
        cause_reg <= cause_reg & req.wdata & `RCV_CAUSE_USED; // RQ6 RQ12
      if (ev_temp)
        cause_reg[`RCV_BIT_TEMP] <= 1'b1; // RQ7
      if (ev_wdog)
        cause_reg[`RCV_BIT_WDOG] <= 1'b1; // RQ8
      if (ev_brown)
        cause_reg[`RCV_BIT_BROWN] <= 1'b1; // RQ9
      if (ev_pin)
        cause_reg[`RCV_BIT_PIN] <= 1'b1; // RQ10
    end
  end

  // control registers, only arst_n clears them
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vmon_reg <= `RCV_CTRL_RST;
      temp_reg <= `RCV_CTRL_RST;
      core_reg <= `RCV_CTRL_RST;
    end
    else if (req.we)
    begin
      if (req.addr == `RCV_OFS_VMON)
        vmon_reg <= req.wdata & 8'h03;
      else if (req.addr == `RCV_OFS_TEMP)
        temp_reg <= req.wdata & 8'h01;
      else if (req.addr == `RCV_OFS_CORE)
        core_reg <= req.wdata & 8'h02;
    end
  end

  // interrupt status, write one to clear, set wins
  assign ev = {ev_temp, ev_wdog, ev_brown, ev_pin};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat_reg <= '0;
    else if (req.we && req.addr == `RCV_OFS_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~req.wdata[`RCV_EV_W-1:0]) | ev;
    else
      irq_stat_reg <= irq_stat_reg | ev;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_mask_reg <= '0;
    else if (req.we && req.addr == `RCV_OFS_IRQ_MASK)
      irq_mask_reg <= req.wdata[`RCV_EV_W-1:0];
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // read port, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (!req.re)
      reg_rdata <= 8'h00;
    else if (req.addr == `RCV_OFS_CAUSE)
      reg_rdata <= cause_reg & `RCV_CAUSE_USED; // RQ6
    else if (req.addr == `RCV_OFS_VMON)
      reg_rdata <= vmon_reg;
    else if (req.addr == `RCV_OFS_TEMP)
      reg_rdata <= temp_reg;
    else if (req.addr == `RCV_OFS_CORE)
      reg_rdata <= core_reg;
    else if (req.addr == `RCV_OFS_IRQ_STAT)
      reg_rdata <= {4'h0, irq_stat_reg};
    else if (req.addr == `RCV_OFS_IRQ_MASK)
      reg_rdata <= {4'h0, irq_mask_reg};
    else if (req.addr == `RCV_OFS_LIVE)
      reg_rdata <= {4'h0, fuse_reg, shutdown_active, core_reset, bo_seen};
    else
      reg_rdata <= 8'h00;
  end

  // fuse low means programmed: boot loader address at reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reset_addr <= `RCV_RESET_ADDR;
    else
      reset_addr <= fuse_reg ? `RCV_RESET_ADDR : BOOT_ADDR; // RQ16 RQ17
  end

  // table base moves to the boot section when selected
  assign vec_base = core_reg[`RCV_BIT_VSEL] ? BOOT_ADDR : `RCV_RESET_ADDR; // RQ15 RQ17

  // lowest pending number wins; scan high to low so the last hit sticks
  always_comb
  begin
    pick_valid = 1'b0;
    pick_idx   = '0;
    for (int i = NUM_VEC - 1; i >= 0; i--)
    begin
      if (irq_req[i])
      begin
        pick_valid = 1'b1;
        pick_idx   = VW'(i); // RQ18
      end
    end
  end

  // vectors follow one another from the first slot after reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_vector <= '0;
    else
    begin
      irq_vector.valid <= pick_valid & ~core_reset;
      irq_vector.addr  <= vec_base + `RCV_VEC_FIRST + `RCV_ADDR_W'(pick_idx); // RQ14
    end
  end

endmodule

`default_nettype wire

// ==== test/rcv_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// core side: first fetch from the reset address, later from served vectors
module rcv_core_model
  import rcv_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           arst_n,
  input  wire logic           core_reset,
  input  wire logic [11:0]    reset_addr,
  input  wire rcv_vector_type irq_vector,
  output var  logic [11:0]    fetch_pc
);
  logic started_reg;

  // fetch only once out of reset, so a late reset address is still seen
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      started_reg <= 1'b0;
      fetch_pc    <= 12'h000;
    end
    else if (core_reset)
      started_reg <= 1'b0;
    else if (!started_reg)
    begin
      started_reg <= 1'b1;
      fetch_pc    <= reset_addr;
    end
    else if (irq_vector.valid)
      fetch_pc <= irq_vector.addr;
  end
endmodule
`default_nettype wire

// ==== test/rcv_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rcv_consts.svh"

// watches the top ports only; one clock domain
module rcv_checker
  import rcv_pkg::*;
(
  input wire logic           clk,
  input wire logic           arst_n,
  input wire logic [2:0]     reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           reg_we,
  input wire logic           reg_re,
  input wire logic [7:0]     reg_rdata,
  input wire logic           boot_reset_fuse,
  input wire logic           watchdog_enable,
  input wire logic           watchdog_timeout,
  input wire logic [25:0]    irq_req,
  input wire logic           brownout_level_select,
  input wire logic           brownout_enable,
  input wire logic           core_reset,
  input wire logic           watchdog_reset_pulse,
  input wire logic           shutdown_active,
  input wire logic [11:0]    reset_addr,
  input wire rcv_vector_type irq_vector
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // low 10 bits of the expected vector: boot base has them clear
  function automatic logic [9:0] low1(logic [25:0] v);
    low1 = 10'h000;
    for (int k = 25; k >= 0; k--)
      if (v[k])
        low1 = 10'(k + 1);
  endfunction

  chk_wdog_pulse: assert property (watchdog_timeout && watchdog_enable && !watchdog_reset_pulse
    |=> watchdog_reset_pulse && core_reset ##1 !watchdog_reset_pulse) else $error("watchdog pulse wrong");
  chk_wdog_delay: assert property ($fell(watchdog_reset_pulse) |-> core_reset [*4])
    else $error("delay not held after watchdog pulse");
  chk_cause_unused: assert property (reg_re && reg_addr == 3'h0 |=> (reg_rdata & 8'hD0) == 8'h00)
    else $error("unused cause bits not zero");
  chk_level_write: assert property (reg_we && reg_addr == 3'h1 && reg_wdata[1:0] == 2'h3
    |=> brownout_level_select && brownout_enable) else $error("level select not applied");
  chk_fuse_addr: assert property ($stable(boot_reset_fuse) [*6]
    |-> reset_addr == (boot_reset_fuse ? `RCV_RESET_ADDR : `RCV_BOOT_ADDR)) else $error("reset address wrong");
  chk_shut_reset: assert property (shutdown_active |-> core_reset)
    else $error("shutdown without reset");
  chk_vec_blocked: assert property (core_reset |=> !irq_vector.valid)
    else $error("vector served in reset");
  chk_vec_prio: assert property (!core_reset && irq_req != 26'h0
    |=> irq_vector.valid && irq_vector.addr[9:0] == low1($past(irq_req))) else $error("vector priority wrong");
endmodule

bind rcv_reset_vector rcv_checker chk_u (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
  .boot_reset_fuse, .watchdog_enable, .watchdog_timeout, .irq_req, .brownout_level_select, .brownout_enable,
  .core_reset, .watchdog_reset_pulse, .shutdown_active, .reset_addr, .irq_vector);
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rcv_consts.svh"

module tb
  import rcv_pkg::*;
;
  logic           clk, arst_n, we, re, sup, pin_n, hot, fuse, wen, wto;
  logic           bsel, ben, crst, wpulse, shut, irq;
  logic [2:0]     addr = 3'h0;
  logic [7:0]     wd = 8'h00;
  logic [7:0]     rdat;
  logic [25:0]    req = 26'h0;
  logic [11:0]    raddr, pc;
  rcv_vector_type vec;
  int             mismatches = 0;
  int             total_checks = 0;
  int             cyc = 0;

  // short delay count keeps every release quick
  rcv_reset_vector #(.TOUT_CYC(4)) dut_u (.clk, .arst_n, .reg_addr(addr), .reg_wdata(wd), .reg_we(we),
    .reg_re(re), .reg_rdata(rdat), .supply_low(sup), .reset_pin_n(pin_n), .overtemp(hot),
    .boot_reset_fuse(fuse), .watchdog_enable(wen), .watchdog_timeout(wto), .irq_req(req),
    .brownout_level_select(bsel), .brownout_enable(ben), .core_reset(crst), .watchdog_reset_pulse(wpulse),
    .shutdown_active(shut), .reset_addr(raddr), .irq_vector(vec), .irq);
  rcv_core_model core_u (.clk, .arst_n, .core_reset(crst), .reset_addr(raddr), .irq_vector(vec), .fetch_pc(pc));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard: the run needs about 900 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(string n, logic [12:0] e, logic [12:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk("reg_rdata", {5'h00, e}, {5'h00, rdat});
  endtask

  // bounded wait for the core to leave reset
  task automatic run();
    int i = 0;
    repeat (3) @(posedge clk);
    while (crst !== 1'b0 && i < 3000)
    begin
      @(negedge clk);
      i++;
    end
    chk("core_reset", 13'h0000, {12'h000, crst});
  endtask

  task automatic por();
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    run();
  endtask

  task automatic wdog(logic e);
    @(posedge clk);
    wen <= e;
    wto <= 1'b1;
    @(posedge clk);
    wto <= 1'b0;
    #1;
    chk("wdog_pulse", {12'h000, e}, {12'h000, wpulse});
  endtask

  task automatic done(string n);
    $display("test %s finished", n);
  endtask

  initial
  begin
    {we, re, sup, hot, wen, wto} = 6'h00;
    {pin_n, fuse} = 2'h3;
    por();
    rd(3'h0, 8'h01);
    rd(3'h7, 8'h00);
    rd(3'h6, 8'h08);
    for (int a = 1; a < 6; a++)
      rd(3'(a), 8'h00);
    wr(3'h1, 8'h03);
    chk("level", 13'h0003, {11'h000, bsel, ben});
    wr(3'h1, 8'h01);
    chk("level", 13'h0001, {11'h000, bsel, ben});
    done("registers");
    wdog(1'b1);
    run();
    rd(3'h0, 8'h09);
    rd(3'h4, 8'h04);
    wr(3'h5, 8'h04);
    chk("irq", 13'h0001, {12'h000, irq});
    wr(3'h4, 8'h04);
    chk("irq", 13'h0000, {12'h000, irq});
    wr(3'h0, 8'h00);
    rd(3'h0, 8'h00);
    wdog(1'b0);
    done("watchdog");
    wr(3'h1, 8'h01);
    @(posedge clk) sup <= 1'b1;
    repeat (100) @(posedge clk);
    sup <= 1'b0;
    rd(3'h0, 8'h00);
    @(posedge clk);
    sup <= 1'b1;
    repeat (250) @(posedge clk);
    #1;
    chk("core_reset", 13'h0001, {12'h000, crst});
    @(posedge clk) sup <= 1'b0;
    run();
    rd(3'h0, 8'h04);
    wr(3'h0, 8'h00);
    @(posedge clk) pin_n <= 1'b0;
    repeat (250) @(posedge clk);
    pin_n <= 1'b1;
    run();
    rd(3'h0, 8'h02);
    done("brownout and pin");
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h01);
    @(posedge clk) hot <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("shutdown", 13'h0003, {11'h000, shut, crst});
    @(posedge clk) hot <= 1'b0;
    run();
    rd(3'h0, 8'h20);
    done("overtemp");
    for (int s = 0; s < 2; s++)
    begin
      wr(3'h3, 8'(2 * s));
      for (int i = 0; i < 26; i++)
      begin
        @(posedge clk);
        req <= (26'h1 << i) | 26'h2000000;
        repeat (2) @(posedge clk);
        #1;
        chk("irq_vector", {1'b1, (s ? `RCV_BOOT_ADDR : 12'h000) + 12'(i + 1)}, vec);
      end
    end
    chk("fetch_pc", {1'b0, `RCV_BOOT_ADDR + 12'h01A}, {1'b0, pc});
    done("vectors");
    @(posedge clk);
    fuse <= 1'b0;
    req <= 26'h0;
    por();
    rd(3'h0, 8'h01);
    chk("reset_addr", {1'b0, `RCV_BOOT_ADDR}, {1'b0, raddr});
    chk("fetch_pc", {1'b0, `RCV_BOOT_ADDR}, {1'b0, pc});
    done("boot fuse");
    final_report();
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
endmodule
`default_nettype wire
